//--- verilog/srs_pkg.sv
// Shared constants for the system reset sequencer
package srs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;        // 200 MHz system clock
    localparam int OSC_START_NS    = 4000;        // Oscillator start-up, 4 us
    // Least time, so round up
    localparam int OSC_START_CYC   = (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_PLAIN_TICK = 66;          // Hold, crystal off
    localparam int HOLD_XTAL_TICK  = 5000;        // Hold, crystal on
    localparam int PIN_FILT_CYC    = 3;           // Low samples counted before the one that accepts the pin
    localparam int SYNC_STAGES     = 2;           // Synchroniser depth
    localparam int CNT_W           = 13;          // Hold/start counter width

    // ------------------------------------------------------------
    // Register map (Avalon byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;    // Control
    localparam logic [3:0] ADDR_STATUS = 4'h4;    // Reset cause flags
    localparam logic [3:0] ADDR_STATE  = 4'h8;    // Sequencer state

    // Control register fields
    localparam int CTRL_DBG_RST = 0;              // Debugger reset request
    localparam int CTRL_IND_EN  = 1;              // Reset indicator enable
    localparam int CTRL_CLK_ALT = 2;              // 1 = non-default clock

    // Status register fields
    localparam int STAT_EXT  = 4;                 // External pin reset
    localparam int STAT_WDT  = 5;                 // Watchdog time-out
    localparam int STAT_STOP = 6;                 // Stop-mode recovery
    localparam int STAT_POR  = 7;                 // Power-on reset

    // Reset vector location in program memory
    localparam logic [15:0] RESET_VEC_ADDR = 16'h0002;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_POWER,                                 // Supply below threshold
        ST_OSC_START,                             // Oscillator start-up
        ST_HOLD,                                  // Counting hold period
        ST_PIN_WAIT,                              // Waiting for pin release
        ST_RUN                                    // Core running
    } srs_state_t;

endpackage

//--- verilog/srs_pin_filt.sv
// Reset pin synchroniser and low-pulse qualifier
`timescale 1ns/100ps
module srs_pin_filt #(
    parameter int STAGES = srs_pkg::SYNC_STAGES,
    parameter int FILT   = srs_pkg::PIN_FILT_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    input  wire logic i_pin,        // Raw pin level
    output logic      o_pin_high,   // Synchronised level
    output logic      o_low_seen    // Pin low long enough
);
    import srs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [STAGES-1:0] sync;    // Bit 0 is the first stage
        logic [3:0]        run;     // Consecutive low samples
        logic              low;     // Qualified assertion
    } srs_filt_t;

    srs_filt_t filt_ff;             // Registered state
    srs_filt_t nxt_filt;            // Next state

    // Refuse settings the synchroniser or counter cannot serve
    if (STAGES < 2 || FILT < 1 || FILT > 15) begin : g_chk
        $error("srs_pin_filt: bad STAGES or FILT");
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_filt      = filt_ff;
        nxt_filt.sync = {filt_ff.sync[STAGES-2:0], i_pin};
        // Only the last stage is looked at
        if (filt_ff.sync[STAGES-1]) begin
            nxt_filt.run = 4'h0;
            nxt_filt.low = 1'b0;
        end else if (filt_ff.run != 4'(FILT)) begin
            nxt_filt.run = filt_ff.run + 4'h1;
        end else begin
            nxt_filt.low = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers, idle pin reads high
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            filt_ff <= '{sync: '1, run: 4'h0, low: 1'b0};
        end else if (i_ce) begin
            filt_ff <= nxt_filt;
        end
    end

    assign o_pin_high = filt_ff.sync[STAGES-1];
    assign o_low_seen = filt_ff.low;

endmodule

//--- verilog/srs_sequencer.sv
// System reset sequencer with Avalon-MM status and control
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/100ps

module srs_sequencer #(
    parameter int HOLD_PLAIN = srs_pkg::HOLD_PLAIN_TICK,
    parameter int HOLD_XTAL  = srs_pkg::HOLD_XTAL_TICK,
    parameter int OSC_CYC    = srs_pkg::OSC_START_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    // Avalon-MM slave
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    // Reset sources
    input  wire logic        i_supply_ok,       // Brown-out detector: supply good
    input  wire logic        i_wdt_timeout,     // Watchdog time-out pulse
    input  wire logic        i_in_stop,         // Core is in stop mode
    input  wire logic        i_stop_pin_wake,   // Stop recovery by pin change
    input  wire logic        i_stop_wdt_wake,   // Stop recovery by watchdog
    input  wire logic        i_xtal_option,     // Option bit: crystal enabled
    input  wire logic        i_ipo_tick,        // One internal osc cycle
    // Reset pin, open drain
    input  wire logic        i_reset_pin,
    output logic             o_reset_pin_out,
    output logic             o_reset_pin_oe,
    // Debug pin, open drain
    input  wire logic        i_dbg_pin,
    input  wire logic        i_dbg_key_seen,    // Entry key sequence seen
    input  wire logic        i_dbg_drive_low,   // Debugger wants pin low
    output logic             o_dbg_pin_out,
    output logic             o_dbg_pin_oe,
    output logic             o_dbg_pin_level,   // Registered pin level
    // Reset outputs
    output logic             o_core_rst,        // Core and peripherals idle
    output logic             o_debugger_rstn,   // Debugger block reset
    output logic             o_gpio_rst,        // Inputs, pull-ups off
    output logic             o_defaults_load,   // Load register defaults
    output logic             o_xtal_run,
    output logic             o_wdt_osc_run,
    output logic             o_sysclk_sel_ipo,
    output logic             o_vector_fetch,    // Fetch reset vector pulse
    output logic [15:0]      o_vector_addr
);
    import srs_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (HOLD_PLAIN < 1 || HOLD_XTAL < 1 || OSC_CYC < 1 ||
        HOLD_PLAIN >= 2**CNT_W || HOLD_XTAL >= 2**CNT_W ||
        OSC_CYC >= 2**CNT_W) begin : g_chk
        $error("srs_sequencer: count does not fit counter");
    end

    localparam logic [CNT_W-1:0] OSC_LAST   = CNT_W'(OSC_CYC - 1);
    localparam logic [CNT_W-1:0] PLAIN_LAST = CNT_W'(HOLD_PLAIN - 1);
    localparam logic [CNT_W-1:0] XTAL_LAST  = CNT_W'(HOLD_XTAL - 1);
    localparam logic [1:0]       SETTLE_MAX = 2'(SYNC_STAGES);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        srs_state_t  state;         // Sequencer state
        logic [CNT_W-1:0] cnt;      // Start-up or hold count
        logic [1:0]  settle;        // Pin release settle count
        logic        sysrst;        // Full system reset, not stop wake
        logic        xtal;          // Latched crystal option
        logic        dbg_req;       // Debugger reset request
        logic        ind_en;        // Indicator enabled by port control
        logic        clk_alt;       // Software picked another clock
        logic        f_por;         // Cause flags
        logic        f_stop;
        logic        f_wdt;
        logic        f_ext;
        logic        waitreq;       // Avalon waitrequest
        logic [31:0] rdata;         // Avalon read data
        logic        core_rst;
        logic        dbg_rstn;
        logic        gpio_rst;
        logic        defaults_ld;
        logic        vec_fetch;
        logic        pin_oe;
        logic        dbg_oe;
        logic        dbg_lvl;
    } srs_regs_t;

    srs_regs_t regs_ff;             // Registered state
    srs_regs_t nxt_regs;            // Next state

    logic pin_high;                 // Synchronised reset pin
    logic pin_low_seen;             // Qualified pin assertion

    // ------------------------------------------------------------
    // Pin synchroniser and qualifier
    // ------------------------------------------------------------
    srs_pin_filt #(
        .STAGES (SYNC_STAGES),
        .FILT   (PIN_FILT_CYC)
    ) u_pin_filt (
        .i_clk      (i_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_pin      (i_reset_pin),
        .o_pin_high (pin_high),
        .o_low_seen (pin_low_seen)
    );

    // ------------------------------------------------------------
    // Read data decode
    // ------------------------------------------------------------
    function automatic logic [31:0] rd_mux(input logic [3:0] addr,
                                           input srs_regs_t r);
        logic [31:0] d;
        d = 32'h0;
        if (addr == ADDR_CTRL) begin
            d[CTRL_DBG_RST] = r.dbg_req;
            d[CTRL_IND_EN]  = r.ind_en;
            d[CTRL_CLK_ALT] = r.clk_alt;
        end else if (addr == ADDR_STATUS) begin
            d[STAT_POR]  = r.f_por;
            d[STAT_STOP] = r.f_stop;
            d[STAT_WDT]  = r.f_wdt;
            d[STAT_EXT]  = r.f_ext;
        end else if (addr == ADDR_STATE) begin
            d[2:0] = r.state;
            d[3]   = r.core_rst;
            d[4]   = r.xtal;
        end
        return d;
    endfunction

    // Start a reset sequence from the oscillator start-up phase
    function automatic srs_regs_t enter_reset(input srs_regs_t r,
                                              input logic full,
                                              input logic xtal);
        srs_regs_t o;
        o          = r;
        o.state    = ST_OSC_START;
        o.cnt      = '0;
        o.sysrst   = full;
        o.xtal     = xtal;
        o.core_rst = 1'b1;
        o.clk_alt  = 1'b0;
        o.dbg_req  = 1'b0;
        if (full) begin
            o.gpio_rst    = 1'b1;
            o.defaults_ld = 1'b1;
            o.ind_en      = 1'b0;
        end
        return o;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic acc;                  // Bus access completes this edge
        logic req;                  // Bus request present
        logic hold_end;             // Last hold tick reached
        acc  = 1'b0;
        req  = 1'b0;
        hold_end = 1'b0;
        nxt_regs = regs_ff;
        nxt_regs.defaults_ld = 1'b0;
        nxt_regs.vec_fetch   = 1'b0;

        // Bus: one wait cycle, then complete
        req = i_read | i_write;
        acc = req & ~regs_ff.waitreq;
        if (acc) begin
            nxt_regs.waitreq = 1'b1;
        end else if (req) begin
            nxt_regs.waitreq = 1'b0;
            nxt_regs.rdata   = rd_mux(i_address, regs_ff);
        end
        if (acc && i_write && i_address == ADDR_CTRL) begin
            nxt_regs.dbg_req = i_writedata[CTRL_DBG_RST];
            nxt_regs.ind_en  = i_writedata[CTRL_IND_EN];
            nxt_regs.clk_alt = i_writedata[CTRL_CLK_ALT];
        end
        // Reading status clears the pin flag; later sets still win
        if (acc && i_read && i_address == ADDR_STATUS) begin
            nxt_regs.f_ext = 1'b0;
        end

        // Sequencer
        case (regs_ff.state)
            ST_POWER: begin
                // Timing starts when supply first reads good
                if (i_supply_ok) begin
                    nxt_regs = enter_reset(nxt_regs, 1'b1, i_xtal_option);
                    nxt_regs.dbg_rstn = 1'b1;
                end
            end
            ST_OSC_START: begin
                if (regs_ff.cnt == OSC_LAST) begin
                    nxt_regs.state = ST_HOLD;
                    nxt_regs.cnt   = '0;
                end else begin
                    nxt_regs.cnt = regs_ff.cnt + 1'b1;
                end
            end
            ST_HOLD: begin
                // Count oscillator ticks, not system clocks
                hold_end = regs_ff.xtal ? (regs_ff.cnt == XTAL_LAST)
                                        : (regs_ff.cnt == PLAIN_LAST);
                if (i_ipo_tick) begin
                    if (hold_end) begin
                        nxt_regs.state  = ST_PIN_WAIT;
                        nxt_regs.settle = 2'h0;
                    end else begin
                        nxt_regs.cnt = regs_ff.cnt + 1'b1;
                    end
                end
            end
            ST_PIN_WAIT: begin
                // Our own drive is off; let it clear the synchroniser
                if (regs_ff.settle != SETTLE_MAX) begin
                    nxt_regs.settle = regs_ff.settle + 2'h1;
                end else if (pin_high) begin
                    nxt_regs.state     = ST_RUN;
                    nxt_regs.core_rst  = 1'b0;
                    nxt_regs.gpio_rst  = 1'b0;
                    nxt_regs.sysrst    = 1'b0;
                    nxt_regs.vec_fetch = 1'b1;
                end
            end
            ST_RUN: begin
                // Priority: debugger, pin, watchdog, stop wakes
                if (regs_ff.dbg_req) begin
                    nxt_regs = enter_reset(nxt_regs, 1'b1, i_xtal_option);
                    {nxt_regs.f_por, nxt_regs.f_stop} = 2'b10;
                    {nxt_regs.f_wdt, nxt_regs.f_ext}  = 2'b00;
                end else if (pin_low_seen) begin
                    nxt_regs = enter_reset(nxt_regs, 1'b1, i_xtal_option);
                    {nxt_regs.f_por, nxt_regs.f_stop} = 2'b00;
                    {nxt_regs.f_wdt, nxt_regs.f_ext}  = 2'b01;
                end else if (i_wdt_timeout && !i_in_stop) begin
                    nxt_regs = enter_reset(nxt_regs, 1'b1, i_xtal_option);
                    {nxt_regs.f_por, nxt_regs.f_stop} = 2'b00;
                    {nxt_regs.f_wdt, nxt_regs.f_ext}  = 2'b10;
                end else if (i_in_stop && i_stop_wdt_wake) begin
                    nxt_regs = enter_reset(nxt_regs, 1'b0, i_xtal_option);
                    {nxt_regs.f_por, nxt_regs.f_stop} = 2'b01;
                    {nxt_regs.f_wdt, nxt_regs.f_ext}  = 2'b10;
                end else if (i_in_stop && i_stop_pin_wake) begin
                    nxt_regs = enter_reset(nxt_regs, 1'b0, i_xtal_option);
                    {nxt_regs.f_por, nxt_regs.f_stop} = 2'b01;
                    {nxt_regs.f_wdt, nxt_regs.f_ext}  = 2'b00;
                end
            end
            default: begin
                nxt_regs.state = ST_POWER;
            end
        endcase

        // Supply loss overrides everything and resets the debugger too
        if (!i_supply_ok) begin
            nxt_regs.state       = ST_POWER;
            nxt_regs.cnt         = '0;
            nxt_regs.sysrst      = 1'b1;
            nxt_regs.core_rst    = 1'b1;
            nxt_regs.gpio_rst    = 1'b1;
            nxt_regs.dbg_rstn    = 1'b0;
            nxt_regs.defaults_ld = 1'b1;
            nxt_regs.dbg_req     = 1'b0;
            nxt_regs.ind_en      = 1'b0;
            nxt_regs.clk_alt     = 1'b0;
            {nxt_regs.f_por, nxt_regs.f_stop} = 2'b10;
            {nxt_regs.f_wdt, nxt_regs.f_ext}  = 2'b00;
        end

        // Pin pulled low until the delay ends on a full reset or with the indicator on, never while we wait for it
        nxt_regs.pin_oe = (nxt_regs.sysrst | nxt_regs.ind_en) &
                          (nxt_regs.state == ST_POWER ||
                           nxt_regs.state == ST_OSC_START ||
                           nxt_regs.state == ST_HOLD);

        // Debug pin stays input in reset unless the key was seen
        nxt_regs.dbg_oe  = i_dbg_drive_low &
                           (~nxt_regs.core_rst | i_dbg_key_seen);
        nxt_regs.dbg_lvl = i_dbg_pin;
    end

    // ------------------------------------------------------------
    // Registers; power-up starts as a power-on reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            regs_ff             <= '0;
            regs_ff.state       <= ST_POWER;
            regs_ff.sysrst      <= 1'b1;
            regs_ff.f_por       <= 1'b1;
            regs_ff.waitreq     <= 1'b1;
            regs_ff.core_rst    <= 1'b1;
            regs_ff.gpio_rst    <= 1'b1;
            regs_ff.defaults_ld <= 1'b1;
            regs_ff.pin_oe      <= 1'b1;
            regs_ff.dbg_lvl     <= 1'b1;
        end else if (i_ce) begin
            regs_ff <= nxt_regs;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from the state register or tied to constants
    // ------------------------------------------------------------
    assign o_readdata       = regs_ff.rdata;
    assign o_waitrequest    = regs_ff.waitreq;
    assign o_reset_pin_out  = 1'b0;
    assign o_reset_pin_oe   = regs_ff.pin_oe;
    assign o_dbg_pin_out    = 1'b0;
    assign o_dbg_pin_oe     = regs_ff.dbg_oe;
    assign o_dbg_pin_level  = regs_ff.dbg_lvl;
    assign o_core_rst       = regs_ff.core_rst;
    assign o_debugger_rstn  = regs_ff.dbg_rstn;
    assign o_gpio_rst       = regs_ff.gpio_rst;
    assign o_defaults_load  = regs_ff.defaults_ld;
    assign o_xtal_run       = regs_ff.xtal;
    assign o_wdt_osc_run    = 1'b1;                         // Never stopped, not even in reset
    assign o_sysclk_sel_ipo = ~regs_ff.clk_alt;
    assign o_vector_fetch   = regs_ff.vec_fetch;
    assign o_vector_addr    = RESET_VEC_ADDR;

endmodule

//--- sim/srs_seq_asserts.sv
// Port-level checks for the reset sequencer
`timescale 1ns/100ps
module srs_seq_asserts #(
    parameter int OSC_CYC = 8
) (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_ce,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic        i_supply_ok,
    input wire logic        i_reset_pin,
    input wire logic        i_dbg_key_seen,
    input wire logic        o_waitrequest,
    input wire logic        o_core_rst,
    input wire logic        o_debugger_rstn,
    input wire logic        o_reset_pin_out,
    input wire logic        o_reset_pin_oe,
    input wire logic        o_dbg_pin_oe,
    input wire logic        o_wdt_osc_run,
    input wire logic        o_sysclk_sel_ipo,
    input wire logic        o_vector_fetch,
    input wire logic [15:0] o_vector_addr
);
    // ------------------------------------------------------------
    // Sequences, one clock domain
    // ------------------------------------------------------------
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_req;
        (i_read || i_write) && o_waitrequest;
    endsequence
    // Four qualified low samples count as a pin reset while the core runs
    sequence s_pin_low4;
        (!i_reset_pin && i_ce)[*4];
    endsequence
    sequence s_leave;
        $fell(o_core_rst);
    endsequence
    a_bus_one_wait: assert property (s_req |=> !o_waitrequest)
        else $error("bus answer late");
    a_pin_wakes: assert property (!o_core_rst ##0 s_pin_low4 |-> ##[1:4] o_core_rst)
        else $error("pin pulse missed");
    a_pin_extends: assert property (o_core_rst && !i_reset_pin |=> o_core_rst)
        else $error("left reset with pin low");
    a_pin_release: assert property ($rose(i_reset_pin) && !o_reset_pin_oe && o_core_rst
        |-> ##[1:6] !o_core_rst)
        else $error("late exit after pin release");
    a_leave_vector: assert property (s_leave |-> o_vector_fetch && o_vector_addr == 16'h0002)
        else $error("no vector fetch on exit");
    a_leave_ipo: assert property (s_leave |-> o_sysclk_sel_ipo)
        else $error("clock not internal on exit");
    a_pin_driven: assert property ($rose(o_core_rst) |-> o_reset_pin_oe && !o_reset_pin_out)
        else $error("reset pin not pulled low");
    a_osc_running: assert property (o_core_rst |-> o_wdt_osc_run)
        else $error("watchdog osc stopped");
    a_power_debug: assert property (!i_supply_ok |-> ##[1:2] !o_debugger_rstn)
        else $error("supply loss not a power reset");
    a_debug_kept: assert property (i_supply_ok[*4] |-> o_debugger_rstn)
        else $error("debugger reset outside power loss");
    a_hold_min: assert property ($rose(o_debugger_rstn) |-> o_core_rst[*8])
        else $error("start-up wait cut short");
    a_dbg_input: assert property (o_dbg_pin_oe |-> !o_core_rst || $past(i_dbg_key_seen))
        else $error("debug pin driven in reset");
endmodule
bind srs_sequencer srs_seq_asserts #(.OSC_CYC(OSC_CYC)) srs_seq_asserts_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_read(i_read), .i_write(i_write),
    .i_supply_ok(i_supply_ok), .i_reset_pin(i_reset_pin), .o_waitrequest(o_waitrequest),
    .o_core_rst(o_core_rst), .o_debugger_rstn(o_debugger_rstn), .i_dbg_key_seen(i_dbg_key_seen),
    .o_reset_pin_out(o_reset_pin_out), .o_reset_pin_oe(o_reset_pin_oe),
    .o_wdt_osc_run(o_wdt_osc_run), .o_sysclk_sel_ipo(o_sysclk_sel_ipo),
    .o_dbg_pin_oe(o_dbg_pin_oe), .o_vector_fetch(o_vector_fetch), .o_vector_addr(o_vector_addr));

//--- sim/srs_board.sv
// Board model: pulled-up reset and debug lines, external reset source
`timescale 1ns/100ps
module srs_board (
    input  wire logic i_clk,
    input  wire logic i_pull_req,   // Bench asks the board to assert reset
    input  wire logic i_rst_oe,     // Device pulling reset line low
    input  wire logic i_dbg_oe,     // Device pulling debug line low
    output logic      o_rst_line,   // Resolved reset line
    output logic      o_dbg_line    // Resolved debug line
);
    logic [2:0] stretch_ff = 3'h0;  // Board never sends a pulse shorter than four clocks
    // Stretch every request so recognition is certain
    always @(posedge i_clk) begin
        stretch_ff <= i_pull_req ? 3'h3 : stretch_ff - {2'h0, stretch_ff != 3'h0};
    end
    // Pull-ups win when nobody drives low
    assign o_rst_line = !(i_pull_req || stretch_ff != 3'h0 || i_rst_oe);
    assign o_dbg_line = !i_dbg_oe;
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb_top;
    import srs_pkg::*;
    localparam int OSC = 8, HP = 4, HX = 6;
    logic        i_clk, i_resetn, i_read, i_write, i_supply_ok, i_wdt_timeout, i_xtal_option;
    logic        i_reset_pin, i_dbg_pin, i_dbg_key_seen, i_dbg_drive_low, pull_req;
    logic        o_waitrequest, o_reset_pin_oe, o_dbg_pin_oe, o_core_rst, o_debugger_rstn;
    logic        o_gpio_rst, o_sysclk_sel_ipo;
    logic [3:0]  i_address;
    logic [31:0] i_writedata, o_readdata, seed, rd;
    int          bad_count, samples_checked, n;
    // ------------------------------------------------------------
    // Design, board and stimulus
    // ------------------------------------------------------------
    srs_sequencer #(.HOLD_PLAIN(HP), .HOLD_XTAL(HX), .OSC_CYC(OSC)) srs_sequencer_inst (
        .i_clk, .i_resetn, .i_ce(1'b1), .i_address, .i_read, .i_write, .i_writedata,
        .o_readdata, .o_waitrequest, .i_supply_ok, .i_wdt_timeout, .i_in_stop(1'b0),
        .i_stop_pin_wake(1'b0), .i_stop_wdt_wake(1'b0), .i_xtal_option, .i_ipo_tick(1'b1),
        .i_reset_pin, .o_reset_pin_out(), .o_reset_pin_oe, .i_dbg_pin, .i_dbg_key_seen,
        .i_dbg_drive_low, .o_dbg_pin_out(), .o_dbg_pin_oe, .o_dbg_pin_level(), .o_core_rst,
        .o_debugger_rstn, .o_gpio_rst, .o_defaults_load(), .o_xtal_run(), .o_wdt_osc_run(),
        .o_sysclk_sel_ipo, .o_vector_fetch(), .o_vector_addr());
    srs_board srs_board_inst (.i_clk(i_clk), .i_pull_req(pull_req), .i_rst_oe(o_reset_pin_oe),
        .i_dbg_oe(o_dbg_pin_oe), .o_rst_line(i_reset_pin), .o_dbg_line(i_dbg_pin));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected hold window, start-up plus hold plus sync slack
    function automatic logic [31:0] in_win(input int got, input logic xt);
        int lo;
        lo = OSC + (xt ? HX : HP);
        return {31'h0, got >= lo && got <= lo + 12};
    endfunction
    // Debug lines wander at random; they must not disturb sequencing
    always @(posedge i_clk) begin
        seed <= i_resetn ? lfsr(seed) : 32'h94196319;
        i_dbg_key_seen <= seed[5];
        i_dbg_drive_low <= seed[9];
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        {i_read, i_write, i_address, i_writedata} <= {!wr, wr, a, d};
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        {i_read, i_write} <= 2'b00;
        @(posedge i_clk);
    endtask
    task automatic until_core(input logic v);
        for (n = 0; o_core_rst !== v && n < 20000; n++) @(posedge i_clk);
    endtask
    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        close_out();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {i_resetn, i_read, i_write, i_wdt_timeout, i_xtal_option, pull_req} = 6'h0;
        {i_supply_ok, i_address, i_writedata} = {1'b1, 4'h0, 32'h0};
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        until_core(1'b0);
        chk(in_win(n, 1'b0), 32'h1);
        bus(0, ADDR_STATUS, 0); chk(rd, 32'h1 << STAT_POR);
        bus(1, 4'hc, seed); bus(0, 4'hc, 0); chk(rd, 32'h0);
        bus(1, ADDR_CTRL, 32'h1 << CTRL_CLK_ALT); chk(o_sysclk_sel_ipo, 1'b0);
        for (int xt = 0; xt < 2; xt++) begin
            i_xtal_option <= xt[0];
            pull_req <= 1'b1;
            repeat (1 + seed[1:0]) @(posedge i_clk);
            pull_req <= 1'b0;
            until_core(1'b1);
            chk(o_gpio_rst, 1'b1);
            until_core(1'b0);
            chk(in_win(n, xt[0]), 32'h1);
            chk(o_sysclk_sel_ipo, 1'b1);
            bus(0, ADDR_STATE, 0); chk(rd, 32'h4 | (xt << 4));
            bus(0, ADDR_STATUS, 0); chk(rd, 32'h1 << STAT_EXT);
            bus(0, ADDR_STATUS, 0); chk(rd, 32'h0);
        end
        i_xtal_option <= 1'b0;
        pull_req <= 1'b1;
        repeat (60) @(posedge i_clk);
        chk(o_core_rst, 1'b1);
        pull_req <= 1'b0;
        until_core(1'b0);
        chk({31'h0, n <= 10}, 32'h1);
        i_wdt_timeout <= 1'b1;
        @(posedge i_clk);
        i_wdt_timeout <= 1'b0;
        until_core(1'b1);
        chk(o_reset_pin_oe, 1'b1);
        until_core(1'b0);
        bus(0, ADDR_STATUS, 0); chk(rd, 32'h1 << STAT_WDT);
        bus(1, ADDR_CTRL, 32'h1 << CTRL_DBG_RST);
        until_core(1'b1);
        chk(o_debugger_rstn, 1'b1);
        until_core(1'b0);
        bus(0, ADDR_STATUS, 0); chk(rd, 32'h1 << STAT_POR);
        bus(0, ADDR_CTRL, 0); chk(rd, 32'h0);
        i_supply_ok <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(o_debugger_rstn, 1'b0);
        i_supply_ok <= 1'b1;
        until_core(1'b0);
        chk(in_win(n, 1'b0), 32'h1);
        close_out();
    end
endmodule
